// ==== asrs_device.sv ====
// Behaviour
// - Convert rise starts conversion; no restart
// - Busy high for whole conversion
// - Core naps after conversion; readout continues
// - Shift only on clock edges, output enabled
// - Host reads after conversion ends
// - Host shift clock fast enough
// - Update on rise; host samples later
// - MSB valid until first rise
// - Normal mode: enable low drives output
// - Enable low: MSB at busy fall
// - Enable falling: MSB appears immediately
// - Host enables one shared device
// - Chain mode: output driven, input data
// - Chain input sampled on rising edges
// - Host: two converts, no clock between
// - Sleep at busy fall after request
// - Clock rise wakes from sleep
// - Host waits wake delay before converting
`timescale 1ns/1ps
`default_nettype none
module asrs_device (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    asrs_if.dev              LINK,
    input  wire logic [17:0] SAMPLE,
    output logic      [17:0] RESULT,
    output logic             CORE_POWERED,
    output logic             ASLEEP,
    output logic             SLEEP_PENDING,
    output logic             START_IGNORED
);
    logic [3:0]  pin_q;
    logic [3:0]  pin_rise;
    logic [3:0]  pin_fall;
    logic        chain_q;
    logic        cnv_rise;
    logic        sck_rise;
    logic        rdl_q;
    logic        rdl_fall;
    asrs_pkg::asrs_pwr_t pwr;
    logic [asrs_pkg::CONV_CNT_W-1:0] conv_cnt;
    logic        conv_done;
    logic        start_ok;
    logic        one_seen;
    logic        second_now;
    logic        sleep_req;
    logic        to_sleep;
    logic        out_en;
    logic        shift_en;
    logic        busy;
    logic [17:0] shreg;

    // Every pin is crossed into the core clock first
    asrs_sync #(
        .W    (4),
        .INIT (4'h1)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RESET),
        .d    ({LINK.daisy_select, LINK.convert_start,
                LINK.sck, LINK.read_enable_sdi}),
        .q    (pin_q),
        .rise (pin_rise),
        .fall (pin_fall)
    );

    assign chain_q  = pin_q[3];
    assign cnv_rise = pin_rise[2];
    assign sck_rise = pin_rise[1];
    assign rdl_q    = pin_q[0];
    assign rdl_fall = pin_fall[0];

    assign start_ok = cnv_rise && (pwr == asrs_pkg::PWR_NAP);
    assign conv_done = (pwr == asrs_pkg::PWR_CONVERT)
                       && (conv_cnt == asrs_pkg::CONV_LAST);
    assign second_now = cnv_rise && one_seen && !sck_rise;
    // A request arriving as busy falls still counts
    assign to_sleep = conv_done && (sleep_req || second_now);

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pwr <= asrs_pkg::PWR_NAP;
        end else begin
            case (pwr)
                asrs_pkg::PWR_NAP: begin
                    if (start_ok) begin
                        pwr <= asrs_pkg::PWR_CONVERT;
                    end
                end
                asrs_pkg::PWR_CONVERT: begin
                    if (to_sleep) begin
                        pwr <= asrs_pkg::PWR_SLEEP;
                    end else if (conv_done) begin
                        pwr <= asrs_pkg::PWR_NAP;
                    end
                end
                asrs_pkg::PWR_SLEEP: begin
                    if (sck_rise) begin
                        pwr <= asrs_pkg::PWR_NAP;
                    end
                end
                default: begin
                    pwr <= asrs_pkg::PWR_NAP;
                end
            endcase
        end
    end

    // Counted from start detection, so busy spans the longest time
    always_ff @(posedge CORE_CLK) begin
        if (RESET || pwr != asrs_pkg::PWR_CONVERT) begin
            conv_cnt <= '0;
        end else begin
            conv_cnt <= conv_cnt + 6'h01;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            busy <= 1'h0;
        end else if (start_ok) begin
            busy <= 1'h1;
        end else if (conv_done) begin
            busy <= 1'h0;
        end
    end

    // Extra starts during a conversion are dropped, not queued
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            START_IGNORED <= 1'h0;
        end else begin
            START_IGNORED <= cnv_rise
                && (pwr == asrs_pkg::PWR_CONVERT);
        end
    end

    // Any shift clock rise breaks a convert pair
    // A convert in the same cycle still opens a new pair
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            one_seen <= 1'h0;
        end else if (cnv_rise) begin
            one_seen <= 1'h1;
        end else if (sck_rise) begin
            one_seen <= 1'h0;
        end
    end

    // Cleared as busy falls; a late request is caught by to_sleep
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sleep_req <= 1'h0;
        end else if (second_now && !conv_done) begin
            sleep_req <= 1'h1;
        end else if (conv_done) begin
            sleep_req <= 1'h0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            RESULT <= '0;
        end else if (conv_done) begin
            RESULT <= SAMPLE;
        end
    end

    // Chain mode always drives; normal mode follows the enable
    assign out_en = chain_q || !rdl_q;
    // Wake-up edge is spent on waking and moves no data
    assign shift_en = sck_rise && out_en
                      && (pwr != asrs_pkg::PWR_SLEEP);

    // Conversion end wins so a fresh result is never lost
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            shreg <= '0;
        end else if (conv_done) begin
            shreg <= SAMPLE;
        end else if (!chain_q && rdl_fall) begin
            shreg <= RESULT;
        end else if (shift_en) begin
            // Chain input enters below, so it leaves 18 clocks later
            shreg <= {shreg[16:0], chain_q & rdl_q};
        end
    end

    assign LINK.busy    = busy;
    assign LINK.sdo_drv = shreg[17];
    assign LINK.sdo_oe  = out_en;
    // Core draws full power only while converting
    assign CORE_POWERED = busy;
    assign SLEEP_PENDING = sleep_req;

    // Registered so the status output is glitch free
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ASLEEP <= 1'h0;
        end else begin
            ASLEEP <= (pwr == asrs_pkg::PWR_SLEEP);
        end
    end
endmodule
`default_nettype wire

// ==== asrs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module asrs_host #(
    parameter int WAKE_DELAY_NS = 1000
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic [4:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic      [1:0]  BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [4:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic      [31:0] RDATA,
    output logic      [1:0]  RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    asrs_if.host             LINK
);
    localparam int TW = asrs_pkg::TMR_W;
    localparam int WAKE_CYC = (WAKE_DELAY_NS
        + asrs_pkg::CLK_PERIOD_NS - 1) / asrs_pkg::CLK_PERIOD_NS;
    localparam logic [TW-1:0] T_HALF = TW'(asrs_pkg::SCK_HALF_CYC - 1);
    localparam logic [TW-1:0] T_FIRST =
        TW'(2 * asrs_pkg::SCK_HALF_CYC - 1);
    localparam logic [TW-1:0] T_CNV = TW'(asrs_pkg::CNV_HIGH_CYC - 1);
    localparam logic [TW-1:0] T_WAKE =
        TW'((WAKE_CYC < 1 ? 1 : WAKE_CYC) - 1);

    logic        aw_held;
    logic [4:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic        w_lo;
    logic        wr_do;
    logic [3:0]  cmd;
    logic        chain;
    logic [5:0]  nbits;
    logic [5:0]  bit_cnt;
    logic [31:0] data;
    logic [1:0]  in_q;
    asrs_pkg::asrs_hstate_t st;
    logic [TW-1:0] tmr;
    logic        second;
    logic        tmr_end;

    asrs_sync #(
        .W    (2),
        .INIT (2'h0)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RESET),
        .d    ({LINK.busy, LINK.sdo_line}),
        .q    (in_q),
        .rise (),
        .fall ()
    );

    assign AWREADY = !aw_held && !BVALID;
    assign WREADY  = !w_held && !BVALID;
    assign ARREADY = !RVALID;
    assign wr_do   = aw_held && w_held && !BVALID;
    assign cmd = (wr_do && w_lo && aw_addr == asrs_pkg::REG_CMD)
                 ? w_data[3:0] : 4'h0;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            aw_held <= 1'h0;
            w_held  <= 1'h0;
            aw_addr <= '0;
            w_data  <= '0;
            w_lo    <= 1'h0;
            BVALID  <= 1'h0;
            BRESP   <= asrs_pkg::RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'h1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'h1;
                w_data <= WDATA;
                w_lo   <= WSTRB[0];
            end
            if (wr_do) begin
                aw_held <= 1'h0;
                w_held  <= 1'h0;
                BVALID  <= 1'h1;
                BRESP   <= (aw_addr == asrs_pkg::REG_CTRL
                    || aw_addr == asrs_pkg::REG_CMD
                    || aw_addr == asrs_pkg::REG_NBITS)
                    ? asrs_pkg::RESP_OKAY : asrs_pkg::RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'h0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            chain <= asrs_pkg::CTRL_RST;
            nbits <= asrs_pkg::NBITS_RST;
        end else if (wr_do && w_lo) begin
            if (aw_addr == asrs_pkg::REG_CTRL) begin
                chain <= w_data[asrs_pkg::CTRL_CHAIN];
            end
            if (aw_addr == asrs_pkg::REG_NBITS) begin
                nbits <= w_data[5:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            RVALID <= 1'h0;
            RDATA  <= '0;
            RRESP  <= asrs_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'h1;
            RRESP  <= asrs_pkg::RESP_OKAY;
            case (ARADDR)
                asrs_pkg::REG_CTRL: RDATA <= {31'h0, chain};
                asrs_pkg::REG_STATUS: RDATA <= {29'h0,
                    st == asrs_pkg::H_WK_WAIT,
                    st != asrs_pkg::H_IDLE, in_q[1]};
                asrs_pkg::REG_DATA: RDATA <= data;
                asrs_pkg::REG_NBITS: RDATA <= {26'h0, nbits};
                asrs_pkg::REG_CMD: RDATA <= '0;
                default: begin
                    RDATA <= '0;
                    RRESP <= asrs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'h0;
        end
    end

    assign tmr_end = (tmr == '0);

    // Orders arriving while a sequence runs are dropped
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            st     <= asrs_pkg::H_IDLE;
            tmr    <= '0;
            second <= 1'h0;
        end else begin
            tmr <= tmr_end ? tmr : tmr - 1'b1;
            case (st)
                asrs_pkg::H_IDLE: begin
                    if (cmd[asrs_pkg::CMD_CONVERT]
                        || cmd[asrs_pkg::CMD_SLEEP]) begin
                        st     <= asrs_pkg::H_CNV_HI;
                        tmr    <= T_CNV;
                        second <= !cmd[asrs_pkg::CMD_CONVERT];
                    end else if (cmd[asrs_pkg::CMD_READ]) begin
                        st <= asrs_pkg::H_RD_WAIT;
                    end else if (cmd[asrs_pkg::CMD_WAKE]) begin
                        st  <= asrs_pkg::H_WK_HI;
                        tmr <= T_HALF;
                    end
                end
                asrs_pkg::H_CNV_HI: begin
                    if (tmr_end) begin
                        st  <= asrs_pkg::H_CNV_LO;
                        tmr <= T_CNV;
                    end
                end
                asrs_pkg::H_CNV_LO: begin
                    if (tmr_end && second) begin
                        st     <= asrs_pkg::H_CNV_HI;
                        tmr    <= T_CNV;
                        second <= 1'h0;
                    end else if (tmr_end) begin
                        st <= asrs_pkg::H_IDLE;
                    end
                end
                asrs_pkg::H_RD_WAIT: begin
                    if (!in_q[1]) begin
                        st  <= asrs_pkg::H_SCK_LO;
                        tmr <= T_FIRST;
                    end
                end
                asrs_pkg::H_SCK_LO: begin
                    if (tmr_end && bit_cnt == nbits - 6'h01) begin
                        st <= asrs_pkg::H_IDLE;
                    end else if (tmr_end) begin
                        st  <= asrs_pkg::H_SCK_HI;
                        tmr <= T_HALF;
                    end
                end
                asrs_pkg::H_SCK_HI: begin
                    if (tmr_end) begin
                        st  <= asrs_pkg::H_SCK_LO;
                        tmr <= T_HALF;
                    end
                end
                asrs_pkg::H_WK_HI: begin
                    if (tmr_end) begin
                        st  <= asrs_pkg::H_WK_WAIT;
                        tmr <= T_WAKE;
                    end
                end
                asrs_pkg::H_WK_WAIT: begin
                    if (tmr_end) begin
                        st <= asrs_pkg::H_IDLE;
                    end
                end
                default: begin
                    st <= asrs_pkg::H_IDLE;
                end
            endcase
        end
    end

    // Bits are taken just before the next rise, after the sync delay
    always_ff @(posedge CORE_CLK) begin
        if (RESET || st == asrs_pkg::H_RD_WAIT) begin
            data    <= '0;
            bit_cnt <= '0;
        end else if (st == asrs_pkg::H_SCK_LO && tmr_end) begin
            data    <= {data[30:0], in_q[0]};
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            LINK.convert_start   <= 1'h0;
            LINK.sck             <= 1'h0;
            LINK.read_enable_sdi <= 1'h1;
            LINK.daisy_select    <= 1'h0;
        end else begin
            LINK.convert_start <= (st == asrs_pkg::H_CNV_HI);
            LINK.sck <= (st == asrs_pkg::H_SCK_HI)
                        || (st == asrs_pkg::H_WK_HI);
            LINK.read_enable_sdi <= !chain
                && (st != asrs_pkg::H_SCK_LO)
                && (st != asrs_pkg::H_SCK_HI);
            LINK.daisy_select <= chain;
        end
    end
endmodule
`default_nettype wire

// ==== asrs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface asrs_if;
    logic convert_start;
    logic sck;
    logic read_enable_sdi;
    logic daisy_select;
    logic busy;
    logic sdo_drv;
    logic sdo_oe;
    logic sdo_line;
    // Undriven line reads high, as with a weak pull-up
    assign sdo_line = sdo_oe ? sdo_drv : 1'h1;
    modport dev (
        input  convert_start,
        input  sck,
        input  read_enable_sdi,
        input  daisy_select,
        output busy,
        output sdo_drv,
        output sdo_oe
    );
    modport host (
        output convert_start,
        output sck,
        output read_enable_sdi,
        output daisy_select,
        input  busy,
        input  sdo_line
    );
endinterface
`default_nettype wire

// ==== asrs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module asrs_monitor (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic convert_start,
    input wire logic sck,
    input wire logic read_enable_sdi,
    input wire logic daisy_select,
    input wire logic busy,
    input wire logic sdo_drv,
    input wire logic sdo_oe
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    logic [6:0] busy_len;
    logic [3:0] quiet;
    logic       sck_q;
    logic       busy_q;
    logic       re_q;
    logic       ds_q;
    logic       ev;
    // Any event that may legally move the output
    assign ev = (sck && !sck_q) || (!busy && busy_q)
        || (!read_enable_sdi && re_q) || (daisy_select != ds_q);
    always_ff @(posedge CORE_CLK) begin
        sck_q <= sck;
        busy_q <= busy;
        re_q <= read_enable_sdi;
        ds_q <= daisy_select;
    end
    always_ff @(posedge CORE_CLK) begin
        if (RESET || !busy) begin
            busy_len <= 7'h00;
        end else if (busy_len != 7'h7F) begin
            busy_len <= busy_len + 7'h01;
        end
    end
    // Pin sync latency allows a few cycles after the event
    always_ff @(posedge CORE_CLK) begin
        if (RESET || ev) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    sequence s_rise;
        $rose(convert_start) && !busy;
    endsequence
    sequence s_pulse;
        (convert_start && !sck) [*4] ##1 !convert_start;
    endsequence
    sequence s_off;
        (!daisy_select && read_enable_sdi) [*5];
    endsequence
    sequence s_on;
        (!daisy_select && !read_enable_sdi) [*5];
    endsequence
    property p_conv_start;
        s_rise |-> ##[1:8] busy;
    endproperty
    property p_busy_len;
        $fell(busy) |-> busy_len >= 7'(asrs_pkg::CONV_CYC - 1)
            && busy_len <= 7'(asrs_pkg::CONV_CYC);
    endproperty
    property p_busy_max;
        busy |-> busy_len < 7'(asrs_pkg::CONV_CYC);
    endproperty
    property p_off;
        s_off |-> !sdo_oe;
    endproperty
    property p_on;
        s_on |-> sdo_oe;
    endproperty
    property p_chain_on;
        daisy_select [*5] |-> sdo_oe;
    endproperty
    property p_shift;
        $changed(sdo_drv) |-> ev || quiet < 4'h8;
    endproperty
    property p_no_sck_busy;
        busy |-> !$rose(sck);
    endproperty
    property p_sel_idle;
        !daisy_select && $fell(read_enable_sdi) |-> !busy;
    endproperty
    property p_cnv_pulse;
        $rose(convert_start) |-> s_pulse;
    endproperty
    a_conv_start: assert property (p_conv_start)
        else $error("busy did not follow convert");
    a_busy_len: assert property (p_busy_len)
        else $error("conversion length wrong");
    a_busy_max: assert property (p_busy_max)
        else $error("conversion too long");
    a_off: assert property (p_off)
        else $error("output driven while disabled");
    a_on: assert property (p_on)
        else $error("output not driven while enabled");
    a_chain_on: assert property (p_chain_on)
        else $error("chain output not driven");
    a_shift: assert property (p_shift)
        else $error("output moved without cause");
    a_no_sck_busy: assert property (p_no_sck_busy)
        else $error("shift clock during conversion");
    a_sel_idle: assert property (p_sel_idle)
        else $error("enable lowered during conversion");
    a_cnv_pulse: assert property (p_cnv_pulse)
        else $error("convert pulse malformed");
endmodule
`default_nettype wire

// ==== asrs_pkg.sv ====
`default_nettype none
package asrs_pkg;
    localparam int RESULT_BITS = 18;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_MAX_NS = 1500;
    // Longest time rounds down
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 6;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST =
        CONV_CNT_W'(CONV_CYC - 1);
    localparam int SCK_HALF_CYC = 4;
    localparam int CNV_HIGH_CYC = 4;
    localparam int TMR_W = 24;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CMD = 5'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] REG_DATA = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_NBITS = 5'h10;
    localparam int CTRL_CHAIN = 0;
    localparam int CMD_CONVERT = 0;
    localparam int CMD_SLEEP = 1;
    localparam int CMD_READ = 2;
    localparam int CMD_WAKE = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_WAKING = 2;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [5:0] NBITS_RST = 6'h12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PWR_NAP,
        PWR_CONVERT,
        PWR_SLEEP
    } asrs_pwr_t;
    typedef enum logic [2:0] {
        H_IDLE,
        H_CNV_HI,
        H_CNV_LO,
        H_RD_WAIT,
        H_SCK_LO,
        H_SCK_HI,
        H_WK_HI,
        H_WK_WAIT
    } asrs_hstate_t;
endpackage
`default_nettype wire

// ==== asrs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module asrs_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] hold;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= INIT;
            q    <= INIT;
            hold <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
            hold <= q;
        end
    end

    assign rise = q & ~hold;
    assign fall = ~q & hold;
endmodule
`default_nettype wire

// ==== test_adc_serial_readout_sleep.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_readout_sleep;
    logic        core_clk;
    logic        reset;
    logic [4:0]  awaddr;
    logic [4:0]  araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [17:0] sample;
    logic [17:0] result;
    logic        asleep;
    logic        ignored;
    logic        powered;
    logic        pending;
    int          failures;
    int          n_checks;
    int          n_ign;
    int          k;
    logic [17:0] tbl [3];
    asrs_if lnk ();
    asrs_device u_asrs_device (.CORE_CLK(core_clk), .RESET(reset),
        .LINK(lnk.dev), .SAMPLE(sample), .RESULT(result),
        .CORE_POWERED(powered), .ASLEEP(asleep), .SLEEP_PENDING(pending),
        .START_IGNORED(ignored));
    asrs_host u_asrs_host (.CORE_CLK(core_clk), .RESET(reset),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .LINK(lnk.host));
    asrs_monitor u_asrs_monitor (.CORE_CLK(core_clk), .RESET(reset),
        .convert_start(lnk.convert_start), .sck(lnk.sck),
        .read_enable_sdi(lnk.read_enable_sdi),
        .daisy_select(lnk.daisy_select), .busy(lnk.busy),
        .sdo_drv(lnk.sdo_drv), .sdo_oe(lnk.sdo_oe));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (ignored === 1'b1) n_ign <= n_ign + 1;
    end
    task end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
        int i;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        chk_word({30'h0, bresp}, {30'h0, e});
        if (i == 50) begin
            failures++;
            end_of_test();
        end
    endtask
    task rd(input logic [4:0] a, input logic [1:0] e);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        chk_word({30'h0, rresp}, {30'h0, e});
        if (i == 50) begin
            failures++;
            end_of_test();
        end
    endtask
    // Polls status; bounded so a stuck sequencer ends the run
    task idle;
        int i;
        for (i = 0; i < 300; i++) begin
            rd(asrs_pkg::REG_STATUS, asrs_pkg::RESP_OKAY);
            if (d[2:0] === 3'h0) break;
        end
        if (i == 300) begin
            failures++;
            end_of_test();
        end
    endtask
    task conv_read(input logic [17:0] s);
        sample <= s;
        wr(asrs_pkg::REG_CMD, 32'h1, asrs_pkg::RESP_OKAY);
        idle();
        chk_word({14'h0, result}, {14'h0, s});
        chk_word({31'h0, powered}, 32'h0);
        wr(asrs_pkg::REG_CMD, 32'h4, asrs_pkg::RESP_OKAY);
        idle();
        rd(asrs_pkg::REG_DATA, asrs_pkg::RESP_OKAY);
    endtask
    initial begin
        reset = 1'b1;
        {awaddr, araddr, wdata, sample} = '0;
        {awvalid, wvalid, arvalid} = '0;
        // Responses are always accepted at once
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        tbl = '{18'h2A5C3, 18'h3FFFF, 18'h00001};
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(asrs_pkg::REG_NBITS, asrs_pkg::RESP_OKAY);
        chk_word(d, {26'h0, asrs_pkg::NBITS_RST});
        rd(asrs_pkg::REG_CTRL, asrs_pkg::RESP_OKAY);
        chk_word(d, 32'h0);
        rd(5'h14, asrs_pkg::RESP_SLVERR);
        chk_word(d, 32'h0);
        wr(5'h1C, 32'h1, asrs_pkg::RESP_SLVERR);
        for (k = 0; k < 3; k++) begin
            conv_read(tbl[k]);
            chk_word(d, {14'h0, tbl[k]});
        end
        wr(asrs_pkg::REG_NBITS, 32'h9, asrs_pkg::RESP_OKAY);
        conv_read(18'h2D2B4);
        chk_word(d, 32'h00000169);
        wstrb <= 4'h0;
        wr(asrs_pkg::REG_CTRL, 32'h1, asrs_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rd(asrs_pkg::REG_CTRL, asrs_pkg::RESP_OKAY);
        chk_word(d, 32'h0);
        wr(asrs_pkg::REG_CTRL, 32'h1, asrs_pkg::RESP_OKAY);
        wr(asrs_pkg::REG_NBITS, 32'h20, asrs_pkg::RESP_OKAY);
        conv_read(18'h1C3A5);
        chk_word({14'h0, d[31:14]}, 32'h0001C3A5);
        // Host holds the upstream input low, so zeros follow
        chk_word({18'h0, d[13:0]}, 32'h0);
        wr(asrs_pkg::REG_CTRL, 32'h0, asrs_pkg::RESP_OKAY);
        wr(asrs_pkg::REG_NBITS, 32'h12, asrs_pkg::RESP_OKAY);
        wr(asrs_pkg::REG_CMD, 32'h2, asrs_pkg::RESP_OKAY);
        // Second pulse lands well inside the first conversion
        repeat (20) @(posedge core_clk);
        chk_word({31'h0, pending}, 32'h1);
        idle();
        chk_word({31'h0, asleep}, 32'h1);
        chk_word({31'h0, pending}, 32'h0);
        chk_word({31'h0, n_ign != 0}, 32'h1);
        wr(asrs_pkg::REG_CMD, 32'h8, asrs_pkg::RESP_OKAY);
        idle();
        chk_word({31'h0, asleep}, 32'h0);
        conv_read(18'h15A5A);
        chk_word(d, 32'h00015A5A);
        end_of_test();
    end
endmodule
`default_nettype wire
